// ===== hdl/srec_pkg.sv
// constants, register map and state type of the reset and exception block
// assumes a single 40 MHz ref_clk that stands for the oscillator clock
package srec_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned NUM_IRQ = 21;
    localparam int unsigned PRE_W   = 13;
    localparam int unsigned WD_W    = 6;   // plain default, width not given
    localparam int unsigned IDX_W   = 5;

    // ------------------------------------------------------------
    // addresses seen on the cpu bus
    // ------------------------------------------------------------
    localparam logic [15:0] WD_SERVICE_ADDR = 16'hFFFF;
    localparam logic [15:0] RESET_VEC_ADDR  = 16'hFFFE;
    localparam logic [15:0] IRQ_VEC_TOP     = 16'hFFFA;

    // ------------------------------------------------------------
    // cycle counts on the prescale counter
    // ------------------------------------------------------------
    localparam logic [12:0] DRIVE_SHORT_CYC = 13'h0020;  // 32
    localparam logic [12:0] HOLD_CYC        = 13'h0020;  // 32
    localparam logic [12:0] OSC_STAB_CYC    = 13'h1000;  // 4096
    localparam logic [12:0] STOP_SHORT_CYC  = 13'h0020;  // 32
    localparam logic [12:0] STOP_LONG_CYC   = 13'h1000;  // 4096
    localparam int unsigned PRE_SVC_LO      = 5;
    localparam int unsigned PRE_SVC_HI      = 12;

    // ------------------------------------------------------------
    // apb register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CAUSE    = 12'h000;
    localparam logic [11:0] ADDR_CFG      = 12'h004;
    localparam logic [11:0] ADDR_IRQ_EN   = 12'h008;
    localparam logic [11:0] ADDR_IRQ_PEND = 12'h00C;
    localparam logic [11:0] ADDR_STATUS   = 12'h010;

    // reset cause bits
    localparam int unsigned CB_POR    = 7;
    localparam int unsigned CB_PIN    = 6;
    localparam int unsigned CB_WD     = 5;
    localparam int unsigned CB_BADOP  = 4;
    localparam int unsigned CB_BADADR = 3;
    localparam int unsigned CB_MON    = 2;
    localparam int unsigned CB_UV     = 1;
    localparam logic [7:0]  CAUSE_RST = 8'h80;

    // config bits
    localparam int unsigned CFG_STOP_EN    = 0;
    localparam int unsigned CFG_SHORT_WAKE = 1;
    localparam logic [1:0]  CFG_RST        = 2'h0;

    // synchroniser lanes
    localparam int unsigned SI_PIN = 0;
    localparam int unsigned SI_VTR = 1;
    localparam int unsigned SI_VTI = 2;
    localparam int unsigned SI_UV  = 3;
    localparam int unsigned SI_POR = 4;
    localparam int unsigned NSYNC  = 5;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_DRIVE = 2'b01,
        ST_HOLD  = 2'b11,
        ST_STOP  = 2'b10
    } srec_state_t;

endpackage

// ===== hdl/srec_irq_if.sv
// signals between the reset sequencer and the interrupt arbiter
// assumes both ends run on ref_clk
`timescale 1ns/1ps
`default_nettype none
interface srec_irq_if;
    import srec_pkg::*;
    logic [NUM_IRQ-1:0] req;
    logic [NUM_IRQ-1:0] en;
    logic               insn_done;
    logic               imask;
    logic               ack;
    logic               rst;
    logic               take;
    logic [15:0]        vec;
    logic               latched;

    modport arb  (input req, en, insn_done, imask, ack, rst, output take, vec, latched);
    modport core (output req, en, insn_done, imask, ack, rst, input take, vec, latched);
endinterface
`default_nettype wire

// ===== hdl/srec_irq_arb.sv
// interrupt latch and priority arbiter
// assumes request lines and cpu strobes come from ref_clk logic
`timescale 1ns/1ps
`default_nettype none
module srec_irq_arb
    import srec_pkg::*;
(
    // clock and reset
    input wire logic  ref_clk,
    input wire logic  srst,
    // link to the sequencer
    srec_irq_if.arb   bus
);

    logic [NUM_IRQ-1:0] live;
    logic [IDX_W-1:0]   win_idx;
    logic               any_live;
    logic               latched_q;
    logic               take_q;
    logic [15:0]        vec_q;
    logic               imask_q;

    // ------------------------------------------------------------
    // priority pick
    // ------------------------------------------------------------
    // lowest index wins
    always_comb begin
        live     = bus.req & bus.en;
        win_idx  = '0;
        any_live = |live;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (live[i]) begin
                win_idx = IDX_W'(i);
            end
        end
    end

    // ------------------------------------------------------------
    // latch and vector
    // ------------------------------------------------------------
    // only at instruction end, unmasked
    always_ff @(posedge ref_clk) begin
        if (srst || bus.rst) begin
            latched_q <= 1'b0;
            take_q    <= 1'b0;
            vec_q     <= RESET_VEC_ADDR;
            imask_q   <= 1'b0;
        end else begin
            imask_q <= bus.imask;
            take_q  <= 1'b0;
            if (latched_q && (bus.ack || (imask_q && !bus.imask))) begin
                latched_q <= 1'b0;
            end else if (!latched_q && bus.insn_done && !bus.imask && any_live) begin
                latched_q <= 1'b1;
                take_q    <= 1'b1;
                vec_q     <= IRQ_VEC_TOP - {10'h000, win_idx, 1'b0};
            end
        end
    end

    assign bus.take    = take_q;
    assign bus.vec     = vec_q;
    assign bus.latched = latched_q;

endmodule
`default_nettype wire

// ===== hdl/srec_top.sv
// reset sequencing, watchdog, prescale counter and exception control
// assumes ref_clk is the oscillator clock, cpu strobes are on ref_clk,
// and the reset pin is open drain with an outside pull-up
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - watchdog overflow raises internal reset and sets its cause bit
// - any write to top vector address clears watchdog and prescaler bits 12..5
// - 13-bit prescaler; its overflow clocks the watchdog
// - watchdog disabled by test voltage on reset or first_ext_interrupt_pin pin in monitor
// - in break state test voltage on reset pin disables watchdog
// - illegal instruction sets its cause bit and resets
// - stop with stop option clear acts as illegal opcode
// - opcode fetch from unmapped address resets; data fetch does not
// - undervoltage sets cause, pin low 4096+32 cycles, cpu released 32 later
// - every internal source drives the reset pin low
// - monitor entry reset input causes internal reset
// - stop instruction clears the prescaler
// - stop exit waits 32 or 4096 cycles per short wake option
// - external reset leaves prescaler alone; it free-runs after resets
// - prescaler times oscillator settling before bus clocks start
// - clock generator enabled once power-on pulse is over
// - interrupt entry stacks registers and sets mask; return restores
// - latched interrupt is not preempted until served or unmasked
// - interrupts taken only at instruction end, unmasked and enabled
// - highest priority first; pending one taken right after return
// - index high byte is never pushed on interrupt entry
// - after 32 pin-low cycles internal reset holds 32 more
// - power-on sets its cause bit and clears the others
// - every reset asserts internal reset and points at reset vector
module srec_top
    import srec_pkg::*;
#(
    parameter logic [12:0] POR_DRIVE_CYC = 13'h1020   // 4096 + 32
) (
    // clock and reset
    input  wire logic               ref_clk,
    input  wire logic               srst,
    // apb slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // open-drain reset pin
    input  wire logic               rst_pin_i,
    output logic                    rst_pin_o,
    output logic                    rst_pin_oe,
    // analog detectors and pin voltage sensing
    input  wire logic               power_on_pulse,
    input  wire logic               undervoltage_in,
    input  wire logic               test_high_voltage_rst,
    input  wire logic               test_high_voltage_first_ext_interrupt_pin,
    // mode inputs
    input  wire logic               monitor_mode,
    input  wire logic               break_state,
    input  wire logic               monitor_entry_reset,
    // cpu bus watch
    input  wire logic [15:0]        cpu_addr,
    input  wire logic               cpu_wr,
    input  wire logic               cpu_opfetch,
    input  wire logic               addr_mapped,
    input  wire logic               illegal_op,
    input  wire logic               stop_exec,
    input  wire logic               stop_wake,
    // interrupt handshake
    input  wire logic               insn_done,
    input  wire logic               cpu_imask,
    input  wire logic               irq_ack,
    input  wire logic [NUM_IRQ-1:0] irq_req,
    // outputs to core and clocks
    output logic                    internal_reset_signal,
    output logic                    internal_bus_clocks_en,
    output logic                    clock_generator_en,
    output logic                    irq_take,
    output logic      [15:0]        vec_addr,
    output logic                    push_index_high
);

    srec_irq_if irq_bus ();

    logic [NSYNC-1:0]   sync1_q;
    logic [NSYNC-1:0]   sync2_q;
    logic               uv_prev_q;
    srec_state_t        state_q;
    srec_state_t        state_d;
    logic [PRE_W-1:0]   cnt_q;
    logic [PRE_W-1:0]   cnt_d;
    logic [WD_W-1:0]    wd_q;
    logic               long_q;
    logic               long_d;
    logic               wake_q;
    logic               short_q;
    logic [7:0]         cause_q;
    logic [1:0]         cfg_q;
    logic [NUM_IRQ-1:0] irq_en_q;
    logic               rst_oe_q;
    logic               internal_reset_signal_q;
    logic               bus_clk_q;
    logic               gen_en_q;
    logic               push_h_q;
    logic [31:0]        prdata_q;
    logic               pready_q;
    logic               pslverr_q;

    logic               pre_ovf;
    logic               wd_dis;
    logic               wd_svc;
    logic               ev_wd;
    logic               ev_op;
    logic               ev_ad;
    logic               ev_uv;
    logic               ev_por;
    logic               ev_mon;
    logic               any_int;
    logic               ext_low;
    logic               stop_ok;
    logic [12:0]        drive_lim;
    logic [12:0]        stop_lim;
    logic               apb_wr;
    logic [31:0]        rd_data;
    logic               rd_hit;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {power_on_pulse, undervoltage_in, test_high_voltage_first_ext_interrupt_pin,
                        test_high_voltage_rst, rst_pin_i};
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------
    always_comb begin
        pre_ovf   = &cnt_q;
        // pin voltage in monitor mode, reset pin voltage in break state
        wd_dis    = (monitor_mode && (sync2_q[SI_VTR] || sync2_q[SI_VTI]))
                  || (break_state && sync2_q[SI_VTR]);
        wd_svc    = cpu_wr && (cpu_addr == WD_SERVICE_ADDR);
        stop_ok   = cfg_q[CFG_STOP_EN];
        ev_wd     = (state_q == ST_RUN) && pre_ovf && (&wd_q) && !wd_dis;
        // illegal opcode, or stop not allowed
        ev_op     = (state_q == ST_RUN) && (illegal_op || (stop_exec && !stop_ok));
        ev_ad     = (state_q == ST_RUN) && cpu_opfetch && !addr_mapped;
        ev_uv     = sync2_q[SI_UV] && !uv_prev_q;
        ev_por    = sync2_q[SI_POR];
        ev_mon    = monitor_entry_reset;
        any_int   = ev_wd || ev_op || ev_ad || ev_uv || ev_por || ev_mon;
        // own drive is masked so it is not read back as an external reset
        ext_low   = !sync2_q[SI_PIN] && !rst_oe_q && (state_q == ST_RUN);
        drive_lim = long_q ? POR_DRIVE_CYC : DRIVE_SHORT_CYC;
        stop_lim  = short_q ? STOP_SHORT_CYC : STOP_LONG_CYC;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            uv_prev_q <= 1'b0;
        end else begin
            uv_prev_q <= sync2_q[SI_UV];
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        long_d  = long_q;
        if (any_int) begin
            state_d = ST_DRIVE;
            long_d  = ev_por || ev_uv || (long_q && state_q == ST_DRIVE);
        end else begin
            case (state_q)
                ST_RUN: begin
                    if (stop_exec && stop_ok) begin
                        state_d = ST_STOP;
                    end
                end
                ST_DRIVE: begin
                    if (cnt_q == drive_lim - 13'h0001) begin
                        state_d = ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (cnt_q == drive_lim + HOLD_CYC - 13'h0001) begin
                        state_d = ST_RUN;
                        long_d  = 1'b0;
                    end
                end
                ST_STOP: begin
                    if (wake_q && cnt_q == stop_lim - 13'h0001) begin
                        state_d = ST_RUN;
                    end
                end
                default: begin
                    state_d = ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= ST_DRIVE;
            long_q  <= 1'b1;
        end else begin
            state_q <= state_d;
            long_q  <= long_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || state_q != ST_STOP) begin
            wake_q  <= 1'b0;
            short_q <= 1'b0;
        end else if (!wake_q && stop_wake) begin
            wake_q  <= 1'b1;
            short_q <= cfg_q[CFG_SHORT_WAKE];
        end
    end

    // ------------------------------------------------------------
    // prescale counter and watchdog
    // ------------------------------------------------------------
    always_comb begin
        cnt_d = cnt_q + 13'h0001;
        // only internal sources and stop clear it; pin reset does not
        // stop clears; held while oscillator is stopped
        if (any_int || (state_q == ST_RUN && stop_exec && stop_ok)
            || (state_q == ST_STOP && !wake_q)) begin
            cnt_d = '0;
        end else if (wd_svc) begin
            cnt_d[PRE_SVC_HI:PRE_SVC_LO] = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || wd_dis || state_q == ST_DRIVE || state_q == ST_HOLD) begin
            wd_q <= '0;
        end else if (wd_svc) begin
            wd_q <= '0;
        end else if (pre_ovf) begin
            wd_q <= wd_q + WD_W'(1);
        end
    end

    // ------------------------------------------------------------
    // reset pin, internal reset, clocks
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rst_oe_q  <= 1'b1;
            internal_reset_signal_q    <= 1'b1;
            bus_clk_q <= 1'b0;
            gen_en_q  <= 1'b0;
            push_h_q  <= 1'b0;
        end else begin
            rst_oe_q  <= (state_d == ST_DRIVE);
            internal_reset_signal_q    <= (state_d == ST_DRIVE) || (state_d == ST_HOLD) || ext_low;
            // bus clocks wait for oscillator settling
            bus_clk_q <= (state_d != ST_STOP)
                      && !(state_d == ST_DRIVE && long_d && cnt_d < OSC_STAB_CYC);
            // clock generator on after power-on pulse
            gen_en_q  <= !sync2_q[SI_POR];
            push_h_q  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // reset cause
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cause_q <= CAUSE_RST;
        end else if (any_int) begin
            // each bit from its own source
            cause_q            <= '0;
            cause_q[CB_POR]    <= ev_por;
            cause_q[CB_WD]     <= ev_wd;
            cause_q[CB_BADOP]  <= ev_op;
            cause_q[CB_BADADR] <= ev_ad;
            cause_q[CB_MON]    <= ev_mon;
            cause_q[CB_UV]     <= ev_uv;
        end else if (ext_low) begin
            cause_q         <= '0;
            cause_q[CB_PIN] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // apb slave, one wait state
    // ------------------------------------------------------------
    assign apb_wr = psel && penable && pwrite && pready_q;

    always_comb begin
        rd_data = '0;
        rd_hit  = 1'b1;
        if (paddr == ADDR_CAUSE) begin
            rd_data[7:0] = cause_q;
        end else if (paddr == ADDR_CFG) begin
            rd_data[1:0] = cfg_q;
        end else if (paddr == ADDR_IRQ_EN) begin
            rd_data[NUM_IRQ-1:0] = irq_en_q;
        end else if (paddr == ADDR_IRQ_PEND) begin
            rd_data[NUM_IRQ-1:0] = irq_req;
        end else if (paddr == ADDR_STATUS) begin
            rd_data[1:0]   = state_q;
            rd_data[2]     = irq_bus.latched;
            rd_data[3]     = wd_dis;
            rd_data[9:4]   = wd_q;
            rd_data[28:16] = cnt_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !rd_hit;
            prdata_q  <= (psel && penable && !pready_q && !pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // config survives internal resets; enables follow them
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_q <= CFG_RST;
        end else if (apb_wr && paddr == ADDR_CFG) begin
            cfg_q <= pwdata[1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || internal_reset_signal_q) begin
            irq_en_q <= '0;
        end else if (apb_wr && paddr == ADDR_IRQ_EN) begin
            irq_en_q <= pwdata[NUM_IRQ-1:0];
        end
    end

    // ------------------------------------------------------------
    // interrupt arbiter
    // ------------------------------------------------------------
    assign irq_bus.req       = irq_req;
    assign irq_bus.en        = irq_en_q;
    assign irq_bus.insn_done = insn_done && !internal_reset_signal_q;
    assign irq_bus.imask     = cpu_imask;
    assign irq_bus.ack       = irq_ack;
    assign irq_bus.rst       = internal_reset_signal_q;

    // take pulse tells the core to stack and set the mask
    srec_irq_arb u_arb (
        .ref_clk (ref_clk),
        .srst    (srst),
        .bus     (irq_bus)
    );

    assign prdata                 = prdata_q;
    assign pready                 = pready_q;
    assign pslverr                = pslverr_q;
    assign rst_pin_o              = 1'b0;
    assign rst_pin_oe             = rst_oe_q;
    assign internal_reset_signal  = internal_reset_signal_q;
    assign internal_bus_clocks_en = bus_clk_q;
    assign clock_generator_en     = gen_en_q;
    assign irq_take               = irq_bus.take;
    assign vec_addr               = irq_bus.vec;
    assign push_index_high        = push_h_q;

endmodule
`default_nettype wire

// ===== testbench/srec_checker.sv
// port assertions for the reset and exception block
// assumes binding into srec_top, single ref_clk domain
`timescale 1ns/1ps
`default_nettype none
module srec_checker
    import srec_pkg::*;
(
    // watched ports
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        rst_pin_oe,
    input wire logic        illegal_op,
    input wire logic        cpu_opfetch,
    input wire logic        addr_mapped,
    input wire logic        insn_done,
    input wire logic        cpu_imask,
    input wire logic        internal_reset_signal,
    input wire logic        internal_bus_clocks_en,
    input wire logic        irq_take,
    input wire logic [15:0] vec_addr,
    input wire logic        push_index_high
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // cpu sources only count while the core runs
    wire logic run = internal_bus_clocks_en && !internal_reset_signal;

    chk_bad_opcode: assert property (illegal_op && run |=> rst_pin_oe && internal_reset_signal)
        else $error("opcode reset missing");
    chk_bad_fetch: assert property (cpu_opfetch && !addr_mapped && run |=> rst_pin_oe)
        else $error("fetch reset missing");
    chk_hold_length: assert property ($fell(rst_pin_oe) |-> ##32 $fell(internal_reset_signal))
        else $error("hold length wrong");
    chk_hold_steady: assert property ($fell(rst_pin_oe) |-> internal_reset_signal [*8])
        else $error("hold dropped early");
    chk_reset_vector: assert property ($fell(internal_reset_signal) |-> vec_addr == RESET_VEC_ADDR)
        else $error("reset vector wrong");
    chk_irq_entry: assert property (irq_take |-> $past(insn_done) && !$past(cpu_imask))
        else $error("irq taken mid insn");
    chk_irq_single: assert property (irq_take |=> !irq_take)
        else $error("irq taken twice");
    chk_no_index: assert property (!push_index_high)
        else $error("index high pushed");
    cover property ($fell(rst_pin_oe));
    cover property (irq_take);
    cover property (illegal_op && run);
endmodule
bind srec_top srec_checker u_chk (.ref_clk, .srst, .rst_pin_oe, .illegal_op, .cpu_opfetch, .addr_mapped,
    .insn_done, .cpu_imask, .internal_reset_signal, .internal_bus_clocks_en, .irq_take, .vec_addr, .push_index_high);
`default_nettype wire

// ===== testbench/srec_pin_model.sv
// reset line outside the chip: pull-up and one outside device
// assumes the open-drain enable of srec_top
`timescale 1ns/1ps
`default_nettype none
module srec_pin_model (
    // line drivers
    input  wire logic oe,
    input  wire logic ext_low,
    // line level
    output logic      level
);
    // chip or outside device pulls low
    assign level = !(oe || ext_low);
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for srec_top
// assumes pin model and checker bind are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
    import srec_pkg::*;
    logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, ext_low = 0, undervoltage_in = 0;
    logic monitor_entry_reset = 0, cpu_wr = 0, cpu_opfetch = 0, addr_mapped = 1, illegal_op = 0;
    logic stop_exec = 0, stop_wake = 0, insn_done = 0, cpu_imask = 0, irq_ack = 0, power_on_pulse = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [15:0] cpu_addr = '0, vec_addr;
    logic [20:0] irq_req = '0;
    logic [32:0] rd;
    logic pready, pslverr, rst_pin_i, rst_pin_o, rst_pin_oe, internal_reset_signal, internal_bus_clocks_en;
    logic clock_generator_en, irq_take, push_index_high;
    logic [7:0] cause_exp [8] = '{8'h10, 8'h10, 8'h08, 8'h04, 8'h02, 8'h40, 8'h80, 8'h80};
    int error_cnt = 0, n_checks = 0, n, lim;

    always #12.5 ref_clk = ~ref_clk;

    srec_top #(.POR_DRIVE_CYC(13'h0040)) dut (.ref_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rst_pin_i, .rst_pin_o, .rst_pin_oe, .power_on_pulse,
        .undervoltage_in, .test_high_voltage_rst(1'b0), .test_high_voltage_first_ext_interrupt_pin(1'b0), .monitor_mode(1'b0),
        .break_state(1'b0), .monitor_entry_reset, .cpu_addr, .cpu_wr, .cpu_opfetch, .addr_mapped, .illegal_op,
        .stop_exec, .stop_wake, .insn_done, .cpu_imask, .irq_ack, .irq_req, .internal_reset_signal,
        .internal_bus_clocks_en, .clock_generator_en, .irq_take, .vec_addr, .push_index_high);
    srec_pin_model pin (.oe(rst_pin_oe), .ext_low, .level(rst_pin_i));

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // returns {pslverr, prdata} taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
        @(posedge ref_clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 0; penable <= 0;
    endtask
    // lets a reset sequence start, then waits for run
    task automatic settle();
        repeat (6) @(posedge ref_clk);
        wait (internal_reset_signal === 1'b0 && internal_bus_clocks_en === 1'b1);
    endtask
    task automatic irq_try(input logic m, input logic [16:0] exp);
        @(posedge ref_clk);
        insn_done <= 1; cpu_imask <= m;
        @(posedge ref_clk);
        insn_done <= 0;
        @(posedge ref_clk);
        chk({16'h0, irq_take, vec_addr}, {16'h0, exp});
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 0;
        settle();
        apb(0, ADDR_CAUSE, 0, rd); chk(rd, 33'h0_0000_0080);
        for (int k = 0; k < 8; k++) begin
            @(posedge ref_clk);
            case (k)
                0: illegal_op <= 1;
                1: stop_exec <= 1;
                2: {cpu_opfetch, addr_mapped} <= 2'b10;
                3: monitor_entry_reset <= 1;
                4: undervoltage_in <= 1;
                5: ext_low <= 1;
                6: power_on_pulse <= 1;
                default: {cpu_opfetch, addr_mapped} <= 2'b00;
            endcase
            @(posedge ref_clk);
            {illegal_op, stop_exec, cpu_opfetch, monitor_entry_reset, undervoltage_in, ext_low, power_on_pulse} <= '0;
            addr_mapped <= 1;
            settle();
            apb(0, ADDR_CAUSE, 0, rd); chk(rd, {25'h0, cause_exp[k]});
            chk(33'(clock_generator_en), 33'h1);
        end
        apb(0, 12'h014, 32'h1234_5678, rd); chk(rd, 33'h1_0000_0000);
        repeat (300) @(posedge ref_clk);
        cpu_addr <= WD_SERVICE_ADDR; cpu_wr <= 1;
        @(posedge ref_clk);
        cpu_wr <= 0;
        apb(0, ADDR_STATUS, 0, rd); chk(33'(rd[28:21] < 8'h02 && rd[9:4] == 6'h00), 33'h1);
        for (int s = 0; s < 2; s++) begin
            apb(1, ADDR_CFG, 32'(3 - 2 * s), rd);
            @(posedge ref_clk) stop_exec <= 1;
            @(posedge ref_clk) stop_exec <= 0;
            repeat (3) @(posedge ref_clk);
            chk(33'(internal_bus_clocks_en), 33'h0);
            stop_wake <= 1;
            @(posedge ref_clk) stop_wake <= 0;
            n = 0;
            do begin @(posedge ref_clk); n++; end while (internal_bus_clocks_en !== 1'b1);
            lim = s ? 4096 : 32;
            chk(33'(n >= lim && n < lim + 8), 33'h1);
        end
        apb(0, ADDR_CFG, 0, rd); chk(rd, 33'h0_0000_0001);
        apb(1, ADDR_IRQ_EN, 32'h001F_FFFF, rd);
        irq_req <= 21'h00_0028;
        irq_try(1, 17'h0_FFFE);
        irq_try(0, 17'h1_FFF4);
        @(posedge ref_clk) irq_ack <= 1;
        @(posedge ref_clk) irq_ack <= 0;
        irq_req <= 21'h00_0020;
        irq_try(0, 17'h1_FFF0);
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
